// *** src/wdg_regs.svh ***
// register map, field positions, reset values and timing counts
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

// ----------------------------------------------------------------
// register map: indices, byte address is four times the index
// ----------------------------------------------------------------
`define WDG_CTRL_IDX 6'h2A
`define WDG_STAT_IDX 6'h2B

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define WDG_ACT_BIT 7
`define WDG_TOP_BIT 6
`define WDG_FLAG_BIT 0
`define WDG_CTRL_RESET 8'h7F
`define WDG_STAT_RESET 8'h00
`define WDG_EXPIRE_FROM 7'h40

// ----------------------------------------------------------------
// timing counts in cpu clock cycles
// ----------------------------------------------------------------
`define WDG_PRESCALE_CYCLES 12288
`define WDG_PRESCALE_W 14
`define WDG_RESET_CYCLES 4096
`define WDG_STABLE_CYCLES 4096
`define WDG_SEQ_W 12

// ----------------------------------------------------------------
// start address fetched on leaving reset
// ----------------------------------------------------------------
`define WDG_RESET_VECTOR 16'hFFFE

`endif

// *** src/wdg_pkg.sv ***
// types shared by the watchdog and reset sequencer
package wdg_pkg;
	// reset sequencer states, one-hot
	typedef enum logic [4:0] {
		SEQ_RESET = 5'b00001,
		SEQ_EXT_HOLD = 5'b00010,
		SEQ_STABLE = 5'b00100,
		SEQ_RUN = 5'b01000,
		SEQ_HALT = 5'b10000
	} seq_state_t;
endpackage

// *** src/prescale_link_if.sv ***
// link between the sequencer and the watchdog prescaler
`timescale 1ns/1ps
`default_nettype none
interface prescale_link_if;
	logic clear;
	logic tick;
	modport owner (output clear, input tick);
	modport divider (input clear, output tick);
endinterface
`default_nettype wire

// *** src/wdg_prescaler.sv ***
// watchdog prescaler: one tick per prescale period
`timescale 1ns/1ps
`default_nettype none
`include "wdg_regs.svh"
module wdg_prescaler #(
	parameter int unsigned PRESCALE_CYCLES = `WDG_PRESCALE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	prescale_link_if.divider link
);
	logic [`WDG_PRESCALE_W-1:0] cnt;
	logic at_last;

	// last count of the period
	assign at_last = cnt == `WDG_PRESCALE_W'(PRESCALE_CYCLES - 1);

	// clear restarts a whole period, so the first tick is never short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			link.tick <= 1'b0;
		end else if (link.clear) begin
			cnt <= '0; // R19
			link.tick <= 1'b0;
		end else begin
			cnt <= at_last ? '0 : cnt + 1'b1; // R1
			link.tick <= at_last;
		end
	end

	a_tick_at_last: assert property (@(posedge pclk) disable iff (!presetn)
		at_last && !link.clear |=> link.tick && cnt == '0) // R1
		else $error("prescaler tick missing at end of period");
	a_clear_restarts: assert property (@(posedge pclk) disable iff (!presetn)
		link.clear |=> cnt == '0 && !link.tick) // R19
		else $error("prescaler not restarted by clear");
endmodule
`default_nettype wire

// *** src/watchdog_and_reset_sequencer.sv ***
// watchdog counter, status flag and reset sequencer with apb registers
//
// Overview of operation
// R1: decrement counter every 12288 cpu cycles
// R2: six low bits set timeout, top bit marks valid
// R3: active and 40h to 3Fh starts reset
// R4: software reloads C0h..FFh before top bit clears
// R5: writing active with top bit clear resets
// R6: activation set by software, cleared by reset
// R7: disabled after reset, then sticky until reset
// R8: halt while active gives full reset
// R9: control reads 7Fh after reset
// R10: inactive counter runs free, never resets
// R11: flag set by watchdog reset, cleared otherwise
// R12: internal reset pulls reset pin low
// R13: every reset lasts 4096 cycles, pin low
// R14: external low of 1.5 cycles is recognised; code needs two low samples in a row
// R15: stay in reset while pin held low
// R16: wait 4096 cycles after power-on or halt exit
// R17: static reset while supply is low
// R18: start address from vector FFFEh
// R19: any reset restarts the prescaler
`timescale 1ns/1ps
`default_nettype none
`include "wdg_regs.svh"
module watchdog_and_reset_sequencer #(
	parameter int unsigned PRESCALE_CYCLES = `WDG_PRESCALE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_n_in,
	output logic reset_pin_n_out,
	output logic reset_pin_n_oe,
	input wire logic low_supply_detect,
	input wire logic safeguard_fault,
	input wire logic halt_request,
	input wire logic wake_request,
	output logic mcu_reset_n,
	output logic cpu_run,
	output logic cpu_halted,
	output logic [15:0] reset_vector
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam logic [`WDG_SEQ_W-1:0] RESET_LAST =
		`WDG_SEQ_W'(`WDG_RESET_CYCLES - 1);
	localparam logic [`WDG_SEQ_W-1:0] STABLE_LAST =
		`WDG_SEQ_W'(`WDG_STABLE_CYCLES - 1);

	wdg_pkg::seq_state_t state;
	wdg_pkg::seq_state_t next_state;
	logic [`WDG_SEQ_W-1:0] seq_cnt;
	logic need_stable;
	logic [1:0] pin_sync;
	logic [1:0] lvd_sync;
	logic pin_prev;
	logic watchdog_activate;
	logic [6:0] countdown_value;
	logic watchdog_reset_flag;
	logic pin_s;
	logic lvd_s;
	logic ext_req;
	logic in_reset;
	logic run_st;
	logic halt_st;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_stat;
	logic ctrl_wr;
	logic stat_wr;
	logic [31:0] rd_mux;
	logic tick;
	logic expire;
	logic sw_reset;
	logic halt_wdg;
	logic wdg_event;
	logic reset_event;
	logic reset_done;
	logic stable_done;

	prescale_link_if pre_link ();

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// a word address hits when the index matches and the byte offset is 0
	function automatic logic word_hit(input logic [7:0] addr,
			input logic [5:0] idx);
		word_hit = addr == {idx, 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// pin and supply detector are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= 2'b11;
			lvd_sync <= 2'b00;
			pin_prev <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[0], reset_pin_n_in};
			lvd_sync <= {lvd_sync[0], low_supply_detect};
			pin_prev <= pin_sync[1];
		end
	end

	// synchronised levels; two low samples in a row count as a request
	assign pin_s = pin_sync[1];
	assign lvd_s = lvd_sync[1];
	assign ext_req = !pin_s && !pin_prev; // R14

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// zero wait states: pready rises in the first access cycle
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign hit_ctrl = word_hit(paddr, `WDG_CTRL_IDX);
	assign hit_stat = word_hit(paddr, `WDG_STAT_IDX);
	assign ctrl_wr = access && pwrite && hit_ctrl && run_st;
	assign stat_wr = access && pwrite && hit_stat && run_st;
	assign rd_mux = hit_ctrl ? {24'h000000, watchdog_activate,
		countdown_value} : hit_stat ? {31'h00000000,
		watchdog_reset_flag} : 32'h00000000;

	// read data is captured in setup, so it shows pre-write state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !(hit_ctrl || hit_stat);
			if (setup) begin
				prdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter
	// ----------------------------------------------------------------
	// the prescaler only runs while the cpu runs; any reset restarts it
	assign pre_link.clear = !run_st; // R19
	assign tick = pre_link.tick;

	// reset causes owned by the watchdog
	assign expire = watchdog_activate && tick && !ctrl_wr &&
		countdown_value == `WDG_EXPIRE_FROM; // R3
	assign sw_reset = ctrl_wr && !pwdata[`WDG_TOP_BIT] &&
		(watchdog_activate || pwdata[`WDG_ACT_BIT]); // R5
	assign halt_wdg = halt_request && watchdog_activate; // R8
	assign wdg_event = run_st && (expire || sw_reset || halt_wdg);

	wdg_prescaler #(
		.PRESCALE_CYCLES(PRESCALE_CYCLES)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.link(pre_link)
	);

	// a software write beats a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_activate <= 1'b0;
			countdown_value <= 7'(`WDG_CTRL_RESET);
		end else if (in_reset) begin
			watchdog_activate <= 1'b0; // R7
			countdown_value <= 7'(`WDG_CTRL_RESET); // R9
		end else if (ctrl_wr) begin
			watchdog_activate <= watchdog_activate ||
				pwdata[`WDG_ACT_BIT]; // R6
			countdown_value <= pwdata[6:0]; // R2
		end else if (tick) begin
			countdown_value <= countdown_value - 7'h01; // R1 R10
		end
	end

	// ----------------------------------------------------------------
	// watchdog reset flag
	// ----------------------------------------------------------------
	// supply loss clears first; a watchdog reset beats a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_reset_flag <= 1'b0;
		end else if (lvd_s) begin
			watchdog_reset_flag <= 1'b0; // R11
		end else if (wdg_event) begin
			watchdog_reset_flag <= 1'b1; // R11
		end else if (reset_event) begin
			watchdog_reset_flag <= 1'b0; // R11
		end else if (stat_wr && !pwdata[`WDG_FLAG_BIT]) begin
			watchdog_reset_flag <= 1'b0; // R11
		end
	end

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	assign in_reset = state == wdg_pkg::SEQ_RESET;
	assign run_st = state == wdg_pkg::SEQ_RUN;
	assign halt_st = state == wdg_pkg::SEQ_HALT;
	assign reset_done = seq_cnt == RESET_LAST;
	assign stable_done = seq_cnt == STABLE_LAST;
	assign reset_event = next_state == wdg_pkg::SEQ_RESET && !in_reset;

	// next state; a low supply overrides every other path
	always_comb begin
		next_state = state;
		case (state)
			wdg_pkg::SEQ_RESET: begin
				if (reset_done) begin
					next_state = wdg_pkg::SEQ_EXT_HOLD; // R13
				end
			end
			wdg_pkg::SEQ_EXT_HOLD: begin
				if (pin_s) begin
					next_state = need_stable ? wdg_pkg::SEQ_STABLE :
						wdg_pkg::SEQ_RUN; // R15
				end
			end
			wdg_pkg::SEQ_STABLE: begin
				if (ext_req) begin
					next_state = wdg_pkg::SEQ_RESET;
				end else if (stable_done) begin
					next_state = wdg_pkg::SEQ_RUN; // R16
				end
			end
			wdg_pkg::SEQ_RUN: begin
				if (wdg_event || ext_req || safeguard_fault) begin
					next_state = wdg_pkg::SEQ_RESET; // R3 R5 R8
				end else if (halt_request) begin
					next_state = wdg_pkg::SEQ_HALT;
				end
			end
			wdg_pkg::SEQ_HALT: begin
				if (ext_req) begin
					next_state = wdg_pkg::SEQ_RESET;
				end else if (wake_request) begin
					next_state = wdg_pkg::SEQ_STABLE; // R16
				end
			end
			default: begin
				next_state = wdg_pkg::SEQ_RESET;
			end
		endcase
		if (lvd_s) begin
			next_state = wdg_pkg::SEQ_RESET; // R17
		end
	end

	// the cycle counter restarts on every state change and on low supply
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= wdg_pkg::SEQ_RESET;
			seq_cnt <= '0;
			need_stable <= 1'b1;
		end else begin
			state <= next_state;
			if (next_state != state || lvd_s) begin
				seq_cnt <= '0; // R17
			end else if (in_reset || state == wdg_pkg::SEQ_STABLE) begin
				seq_cnt <= seq_cnt + 1'b1; // R13 R16
			end
			if (lvd_s) begin
				need_stable <= 1'b1; // R16
			end else if (next_state == wdg_pkg::SEQ_RUN) begin
				need_stable <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// all sequencer outputs but the vector are registered from the next state; the pin is
	// open-drain, so only the enable moves and the data stays low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pin_n_out <= 1'b0;
			reset_pin_n_oe <= 1'b0;
			mcu_reset_n <= 1'b0;
			cpu_run <= 1'b0;
			cpu_halted <= 1'b0;
			reset_vector <= `WDG_RESET_VECTOR;
		end else begin
			reset_pin_n_out <= 1'b0;
			reset_pin_n_oe <= next_state != wdg_pkg::SEQ_RESET; // R12
			mcu_reset_n <= next_state != wdg_pkg::SEQ_RESET &&
				next_state != wdg_pkg::SEQ_EXT_HOLD;
			cpu_run <= next_state == wdg_pkg::SEQ_RUN;
			cpu_halted <= next_state == wdg_pkg::SEQ_HALT;
			reset_vector <= `WDG_RESET_VECTOR; // R18
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_expiry_resets: assert property (@(posedge pclk) // R3
		disable iff (!presetn)
		run_st && !lvd_s && watchdog_activate && tick && !ctrl_wr &&
		countdown_value == 7'h40 |=> in_reset ##1 !reset_pin_n_oe)
		else $error("expiry did not start a reset cycle");

	a_sw_reset_now: assert property (@(posedge pclk) // R5
		disable iff (!presetn)
		run_st && !lvd_s && access && pwrite && hit_ctrl && pwdata[7] &&
		!pwdata[6] |=> in_reset && watchdog_reset_flag)
		else $error("software reset write not honoured");

	a_act_sticky: assert property (@(posedge pclk) // R6
		disable iff (!presetn)
		watchdog_activate && next_state != wdg_pkg::SEQ_RESET &&
		!in_reset |=> watchdog_activate)
		else $error("activation bit cleared without reset");

	a_ctrl_after_reset: assert property (@(posedge pclk) // R9
		disable iff (!presetn)
		in_reset |=> !watchdog_activate && countdown_value == 7'h7F)
		else $error("control register not 7Fh after reset");

	a_free_timer: assert property (@(posedge pclk) // R10
		disable iff (!presetn)
		run_st && !watchdog_activate && tick && !ctrl_wr &&
		!halt_request && !ext_req && !safeguard_fault && !lvd_s
		|=> run_st && countdown_value == $past(countdown_value) - 7'h01)
		else $error("inactive timer did not count down freely");

	a_flag_on_wdg: assert property (@(posedge pclk) // R11
		disable iff (!presetn)
		wdg_event && !lvd_s |=> watchdog_reset_flag [*2])
		else $error("watchdog reset did not set flag");

	a_pin_follows: assert property (@(posedge pclk) // R12
		disable iff (!presetn)
		in_reset |-> !reset_pin_n_oe && !reset_pin_n_out && !mcu_reset_n)
		else $error("reset pin not driven low during reset");

	a_reset_length: assert property (@(posedge pclk) // R13
		disable iff (!presetn)
		in_reset && !lvd_s && seq_cnt != 12'hFFF |=> in_reset)
		else $error("reset cycle ended early");

	a_ext_hold: assert property (@(posedge pclk) // R15
		disable iff (!presetn)
		state == wdg_pkg::SEQ_EXT_HOLD && !pin_s && !lvd_s
		|=> state == wdg_pkg::SEQ_EXT_HOLD)
		else $error("left reset while pin held low");

	a_halt_resets: assert property (@(posedge pclk) // R8
		disable iff (!presetn)
		run_st && halt_request && watchdog_activate |=> in_reset)
		else $error("halt while active did not reset");

	a_stable_wait: assert property (@(posedge pclk) // R16
		disable iff (!presetn)
		$rose(state == wdg_pkg::SEQ_STABLE) |-> seq_cnt == '0 ##1
		(state == wdg_pkg::SEQ_STABLE || in_reset) && !cpu_run)
		else $error("stabilisation wait skipped");

	a_lvd_static: assert property (@(posedge pclk) // R17
		disable iff (!presetn)
		lvd_s |=> in_reset && seq_cnt == '0 ##1 !reset_pin_n_oe)
		else $error("low supply did not hold reset");

	a_ext_recognised: assert property (@(posedge pclk) // R14
		disable iff (!presetn)
		run_st && !pin_s && !pin_prev |=> in_reset)
		else $error("external reset low not recognised");
endmodule
`default_nettype wire

// *** verification/ext_reset_source.sv ***
// model of the external reset circuitry on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module ext_reset_source (
	input wire logic pclk,
	input wire logic reset_pin_n_oe,
	output logic pin
);
	logic ext_low = 1'b0;

	// wired-and with pull-up: low when either side pulls, else high
	assign pin = (!reset_pin_n_oe || ext_low) ? 1'b0 : 1'b1;

	// pull the pin low for n cycles; one cycle may be missed, so 2 minimum
	task automatic pull(input int n);
		int k;
		k = (n < 2) ? 2 : n;
		@(posedge pclk);
		ext_low <= 1'b1;
		repeat (k) @(posedge pclk);
		ext_low <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/test_watchdog_and_reset_sequencer.sv ***
// self-checking testbench for the watchdog and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_and_reset_sequencer;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	// short prescale keeps the run brief; the 4096 counts stay as built
	localparam int PS = 8;
	localparam logic [7:0] CTRL = 8'hA8;
	localparam logic [7:0] STAT = 8'hAC;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, seed;
	logic pin, reset_pin_n_oe, low_supply_detect, safeguard_fault;
	logic pin_out;
	logic halt_request, wake_request, mcu_reset_n, cpu_run, cpu_halted;
	logic [15:0] reset_vector;
	logic [33:0] note;
	logic [33:0] notes [$];
	int miscompares, n_compared, n;

	watchdog_and_reset_sequencer #(.PRESCALE_CYCLES(PS))
		i_watchdog_and_reset_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reset_pin_n_in(pin),
		.reset_pin_n_out(pin_out), .reset_pin_n_oe(reset_pin_n_oe),
		.low_supply_detect(low_supply_detect),
		.safeguard_fault(safeguard_fault), .halt_request(halt_request),
		.wake_request(wake_request), .mcu_reset_n(mcu_reset_n),
		.cpu_run(cpu_run), .cpu_halted(cpu_halted),
		.reset_vector(reset_vector));

	ext_reset_source i_ext_reset_source (.pclk(pclk),
		.reset_pin_n_oe(reset_pin_n_oe), .pin(pin));

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// one apb transfer; the note tells the monitor what to expect
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic chk, input logic [7:0] e);
		int k;
		logic err;
		err = (a !== CTRL) && (a !== STAT);
		notes.push_back({chk, err, (err ? 32'h0 : {24'h0, e})});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		check(k < 20, 1, "bus answer");
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00, 1'b1, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 1'b0, 8'h00);
	endtask

	// bounded wait for execution; n keeps the cycles it took
	task automatic wait_run();
		n = 0;
		while (cpu_run !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		check(mcu_reset_n, 1, "running");
		check(cpu_run, 1, "executing");
	endtask

	// reset onset within [lo,hi], pin pulse length, then register state
	task automatic reset_seen(input int lo, input int hi,
		input logic [7:0] flag);
		int k;
		k = 0;
		while (mcu_reset_n !== 1'b0 && k <= hi) begin
			@(posedge pclk);
			k++;
		end
		check(k >= lo && k <= hi, 1, "reset onset");
		k = 0;
		while (reset_pin_n_oe !== 1'b0 && k < 8) begin
			@(posedge pclk);
			k++;
		end
		check(pin_out, 0, "pin data low");
		k = 0;
		while (reset_pin_n_oe === 1'b0 && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		check(k, 4096, "pin low cycles");
		wait_run();
		rd(STAT, flag);
		rd(CTRL, 8'h7F);
	endtask

	// monitor: the oldest note is compared with each bus answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			check({31'h0, pslverr}, {31'h0, note[32]}, "response");
			if (note[33])
				check(prdata, note[31:0], "read data");
		end
	end

	// ------------------------------------------------------------
	// clock, watchdog and test sequence
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// the whole run needs about 55000 cycles; margin for a slow reset
	initial begin
		repeat (80000) @(posedge pclk);
		miscompares++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		end_of_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		low_supply_detect = 1'b0;
		safeguard_fault = 1'b0;
		halt_request = 1'b0;
		wake_request = 1'b0;
		seed = 32'h42;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_run();
		check(reset_vector, 32'hFFFE, "vector");
		rd(CTRL, 8'h7F);
		rd(STAT, 8'h00);
		rd(8'hB0, 8'h00);
		rd(8'hA9, 8'h00);
		done("reset values");
		wr(CTRL, 8'h3F);
		repeat (12 * PS) @(posedge pclk);
		apb(1'b0, CTRL, 8'h00, 1'b0, 8'h00);
		check(q[7:0] >= 8'h31 && q[7:0] <= 8'h34, 1, "free count");
		check(cpu_run, 1, "inactive never resets");
		done("free count");
		// random reloads never below C7h, so no two ticks can expire it
		repeat (6) begin
			seed = xs(seed);
			wr(CTRL, {2'b11, seed[5:3], 3'h7});
			repeat (PS) @(posedge pclk);
			check(cpu_run, 1, "reload keeps running");
		end
		wr(CTRL, 8'h7F);
		apb(1'b0, CTRL, 8'h00, 1'b0, 8'h00);
		check(q[7], 1, "activation sticky");
		wr(CTRL, 8'hC1);
		reset_seen(PS, 2 * PS + 6, 8'h01);
		done("timeout");
		wr(STAT, 8'h01);
		rd(STAT, 8'h01);
		wr(STAT, 8'h00);
		rd(STAT, 8'h00);
		wr(CTRL, 8'h80);
		reset_seen(0, 4, 8'h01);
		wr(CTRL, 8'hFF);
		@(posedge pclk);
		halt_request <= 1'b1;
		@(posedge pclk);
		halt_request <= 1'b0;
		reset_seen(0, 6, 8'h01);
		done("software and halt resets");
		// flag left set on purpose: a halt and wake must not touch it
		@(posedge pclk);
		halt_request <= 1'b1;
		@(posedge pclk);
		halt_request <= 1'b0;
		repeat (20) @(posedge pclk);
		check({cpu_halted, cpu_run}, 2'b10, "halted");
		wake_request <= 1'b1;
		@(posedge pclk);
		wake_request <= 1'b0;
		wait_run();
		check(n >= 4094 && n <= 4102, 1, "stabilise");
		rd(STAT, 8'h01);
		done("halt wake");
		fork
			i_ext_reset_source.pull(3);
			reset_seen(0, 10, 8'h00);
		join
		fork
			i_ext_reset_source.pull(6000);
			begin
				repeat (5500) @(posedge pclk);
				check(mcu_reset_n, 0, "held by pin");
			end
		join
		wait_run();
		done("external");
		low_supply_detect <= 1'b1;
		repeat (6000) @(posedge pclk);
		check({mcu_reset_n, reset_pin_n_oe}, 2'b00, "supply low");
		low_supply_detect <= 1'b0;
		wait_run();
		rd(STAT, 8'h00);
		@(posedge pclk);
		safeguard_fault <= 1'b1;
		@(posedge pclk);
		safeguard_fault <= 1'b0;
		reset_seen(0, 6, 8'h00);
		done("supply and safeguard");
		end_of_test();
	end
endmodule
`default_nettype wire
